/* File: core/parallel_port_handshake.sv */
// Operation
// R1: handshake_off hands ack/busy to force bits
// R2: host presents byte, then raises strobe
// R3: xfer_active set on strobe leading edge
// R4: busy within three clocks of chosen edge
// R5: ack_after_busy=0: ack rises with busy
// R6: after busy raise inbound service request
// R7: full_word_sel: request every fourth byte
// R8: ack_after_busy=0: drop both after interval/read/strobe
// R9: ack_after_busy=1: busy off, ack on, hold interval
// R10: xfer_active cleared when ack drops
// R11: buffer access tagged DMA or processor
// R12: autofeed level readable as status bit
// R13: direction_bit holds busy active
// R14: direction changed only while mode disabled
// R15: direction set raises first outbound request
// R16: data write becomes buffer write strobe
// R17: setup interval, then ack when ready
// R18: outbound ack lasts one interval
// R19: host strobe confirms byte, clears xfer_active
// R20: host autofeed high means ready
// R21: hold interval after later event, then request
// R22: no data write means no new handshake
// R23: intervals counted from eight-bit delay field
// R24: mode selects service style; off resets
// R25: data access clears data_request_flag
// R26: strobe and autofeed two-stage synchronised
// R27: strobe edges as one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module parallel_port_handshake
#(
   parameter int DATA_W = 32
)
(
   input wire logic mclk, // memory clock, 100 MHz
   input wire logic rst_n, // synchronous reset
   input wire logic [7:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input wire logic dma_cycle, // current bus access comes from dma
   input wire logic host_strobe, // host strobe, high active
   input wire logic host_autofeed, // host autofeed, high active
   output logic port_ack, // acknowledge to host
   output logic port_busy, // busy to host
   output logic irq_req, // interrupt service request
   output logic dma_req0, // dma channel 0 request
   output logic dma_req1, // dma channel 1 request
   output logic buf_req, // external buffer access request
   input wire logic buf_gnt, // buffer access granted
   output logic buf_dma, // access is dma class
   output logic buf_oe_n, // buffer output enable
   output logic buf_we_n, // buffer write strobe
   output logic [DATA_W-1:0] buf_wdata, // data to buffer
   input wire logic [DATA_W-1:0] buf_rdata // data from buffer
);
   // input synchronisers
   logic stb_s1_ff, stb_s2_ff, stb_s3_ff, afd_s1_ff, afd_s2_ff;
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         stb_s1_ff <= 1'b0;
         stb_s2_ff <= 1'b0;
         stb_s3_ff <= 1'b0;
         afd_s1_ff <= 1'b0;
         afd_s2_ff <= 1'b0;
      end
      else
      begin
         stb_s1_ff <= host_strobe; // [R26]
         stb_s2_ff <= stb_s1_ff; // [R26]
         stb_s3_ff <= stb_s2_ff;
         afd_s1_ff <= host_autofeed; // [R26]
         afd_s2_ff <= afd_s1_ff; // [R26]
      end
   end
   logic stb_rise, stb_fall;
   assign stb_rise = stb_s2_ff & ~stb_s3_ff; // [R27]
   assign stb_fall = ~stb_s2_ff & stb_s3_ff; // [R27]

   // bus slave state
   pport_pkg::bus_state_e bus_ff, nxt_bus;
   logic [3:0] bcnt_ff, nxt_bcnt;
   logic brd_ff, nxt_brd;
   logic dma_ff, nxt_dma;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [DATA_W-1:0] wdata_ff, nxt_wdata;
   // handshake state
   pport_pkg::hs_state_e hs_ff, nxt_hs;
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [7:0] cnt_ff, nxt_cnt;
   logic [7:0] fcnt_ff, nxt_fcnt;
   logic [1:0] bct_ff, nxt_bct;
   logic drq_ff, nxt_drq;
   logic xfer_ff, nxt_xfer;
   logic seen_ff, nxt_seen;

   logic is_data, data_rd_done, data_wr_done, reg_wr_done;
   logic [1:0] mode;
   logic [7:0] delay;
   logic hw_busy, hw_ack, force_ack_bit_on, expired;
   logic [31:0] wmask, ctrl_view, stat_view;

   assign mode = ctrl_ff[pport_pkg::MODE_MSB:pport_pkg::MODE_LSB];
   assign delay = ctrl_ff[pport_pkg::DELAY_MSB:pport_pkg::DELAY_LSB];
   assign expired = (cnt_ff == 8'h00);
   assign is_data = (avs_address == pport_pkg::DATA_OFS);
   assign data_rd_done = (bus_ff == pport_pkg::BUS_DONE) && brd_ff && is_data;
   assign data_wr_done = (bus_ff == pport_pkg::BUS_DONE) && !brd_ff && is_data;
   assign reg_wr_done = (bus_ff == pport_pkg::BUS_DONE) && avs_write && !is_data;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & pport_pkg::CTRL_WMASK;

   always_comb
   begin
      ctrl_view = ctrl_ff & pport_pkg::CTRL_WMASK;
      ctrl_view[pport_pkg::DRQ_BIT] = drq_ff;
      ctrl_view[pport_pkg::XFER_BIT] = xfer_ff;
      ctrl_view[pport_pkg::AFD_BIT] = afd_s2_ff; // [R12]
      stat_view = 32'h0000_0000;
      stat_view[pport_pkg::STB_BIT] = stb_s2_ff;
      stat_view[pport_pkg::DELAY_MSB:pport_pkg::DELAY_LSB] = cnt_ff;
      stat_view[pport_pkg::BCT_MSB:pport_pkg::BCT_LSB] = bct_ff;
      stat_view[pport_pkg::BSY_BIT] = port_busy;
      stat_view[pport_pkg::ACK_BIT] = port_ack;
   end

   // bus slave: registers answer after one wait cycle, data after buffer cycle
   always_comb
   begin
      nxt_bus = bus_ff;
      nxt_bcnt = bcnt_ff;
      nxt_brd = brd_ff;
      nxt_dma = dma_ff;
      nxt_rdata = rdata_ff;
      nxt_wdata = wdata_ff;
      unique case (bus_ff)
         pport_pkg::BUS_IDLE:
         begin
            if (avs_read || avs_write)
            begin
               nxt_brd = avs_read;
               if (is_data)
               begin
                  nxt_bus = pport_pkg::BUS_ARB;
                  nxt_dma = dma_cycle; // [R11]
                  nxt_wdata = avs_writedata[DATA_W-1:0];
               end
               else
               begin
                  nxt_bus = pport_pkg::BUS_DONE;
                  if (avs_address == pport_pkg::CTRL_OFS)
                     nxt_rdata = ctrl_view;
                  else if (avs_address == pport_pkg::STAT_OFS)
                     nxt_rdata = stat_view;
                  else
                     nxt_rdata = 32'h0000_0000;
               end
            end
         end
         pport_pkg::BUS_ARB:
         begin
            // arbitrated like any other bus access
            if (buf_gnt) // [R11]
            begin
               nxt_bus = pport_pkg::BUS_STROBE;
               nxt_bcnt = pport_pkg::BUF_STROBE_CYC - 4'h1;
            end
         end
         pport_pkg::BUS_STROBE:
         begin
            if (bcnt_ff == 4'h0)
            begin
               nxt_bus = pport_pkg::BUS_DONE;
               nxt_rdata = 32'(buf_rdata);
            end
            else
               nxt_bcnt = bcnt_ff - 4'h1;
         end
         pport_pkg::BUS_DONE:
            nxt_bus = pport_pkg::BUS_IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         bus_ff <= pport_pkg::BUS_IDLE;
         bcnt_ff <= 4'h0;
         brd_ff <= 1'b0;
         dma_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         wdata_ff <= '0;
      end
      else
      begin
         bus_ff <= nxt_bus;
         bcnt_ff <= nxt_bcnt;
         brd_ff <= nxt_brd;
         dma_ff <= nxt_dma;
         rdata_ff <= nxt_rdata;
         wdata_ff <= nxt_wdata;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && (bus_ff != pport_pkg::BUS_DONE);
   assign avs_readdata = rdata_ff;
   assign buf_req = (bus_ff == pport_pkg::BUS_ARB);
   assign buf_dma = dma_ff;
   assign buf_oe_n = !((bus_ff == pport_pkg::BUS_STROBE) && brd_ff);
   assign buf_we_n = !((bus_ff == pport_pkg::BUS_STROBE) && !brd_ff); // [R16]
   assign buf_wdata = wdata_ff;

   // handshake engine, control register and interval timers
   always_comb
   begin
      nxt_hs = hs_ff;
      nxt_ctrl = ctrl_ff;
      nxt_cnt = expired ? 8'h00 : cnt_ff - 8'h01; // [R23]
      nxt_fcnt = (fcnt_ff == 8'h00) ? 8'h00 : fcnt_ff - 8'h01;
      nxt_bct = bct_ff;
      nxt_drq = drq_ff;
      nxt_xfer = xfer_ff;
      nxt_seen = seen_ff;
      // force-ack runs its own timer so it works with handshaking off
      if (ctrl_ff[pport_pkg::FORCE_ACK_BIT_BIT] && fcnt_ff == 8'h00)
         nxt_ctrl[pport_pkg::FORCE_ACK_BIT_BIT] = 1'b0;
      if (data_rd_done || data_wr_done)
         nxt_drq = 1'b0; // [R25]
      unique case (hs_ff)
         pport_pkg::HS_IDLE:
         begin
            if (ctrl_ff[pport_pkg::DIR_BIT])
            begin
               nxt_drq = 1'b1; // [R15]
               nxt_hs = pport_pkg::HS_OUT_REQ;
            end
            else if (stb_rise)
            begin
               nxt_xfer = 1'b1; // [R3]
               if (ctrl_ff[pport_pkg::BRS_BIT])
                  nxt_hs = pport_pkg::HS_IN_EDGE;
               else
               begin
                  nxt_hs = pport_pkg::HS_IN_BUSY; // [R4]
                  nxt_cnt = delay;
                  if (!ctrl_ff[pport_pkg::FWT_BIT] || bct_ff == pport_pkg::FWT_LAST) // [R7]
                  begin
                     nxt_drq = 1'b1; // [R6]
                     nxt_bct = 2'h0;
                  end
                  else
                     nxt_bct = bct_ff + 2'h1;
               end
            end
         end
         pport_pkg::HS_IN_EDGE:
         begin
            if (stb_fall)
            begin
               nxt_hs = pport_pkg::HS_IN_BUSY; // [R4]
               nxt_cnt = delay;
               if (!ctrl_ff[pport_pkg::FWT_BIT] || bct_ff == pport_pkg::FWT_LAST) // [R7]
               begin
                  nxt_drq = 1'b1; // [R6]
                  nxt_bct = 2'h0;
               end
               else
                  nxt_bct = bct_ff + 2'h1;
            end
         end
         pport_pkg::HS_IN_BUSY:
         begin
            // drq low means the word was read or none was requested
            if (ctrl_ff[pport_pkg::ARB_BIT])
            begin
               if (!drq_ff && !stb_s2_ff)
               begin
                  nxt_hs = pport_pkg::HS_IN_ACK; // [R9]
                  nxt_cnt = delay;
               end
            end
            else if (expired && !drq_ff && !stb_s2_ff)
            begin
               nxt_hs = pport_pkg::HS_IDLE; // [R8]
               nxt_xfer = 1'b0; // [R10]
            end
         end
         pport_pkg::HS_IN_ACK:
         begin
            if (expired)
            begin
               nxt_hs = pport_pkg::HS_IDLE; // [R9]
               nxt_xfer = 1'b0; // [R10]
            end
         end
         pport_pkg::HS_OUT_REQ:
         begin
            // parked here until software or dma writes the data
            if (data_wr_done) // [R22]
            begin
               nxt_hs = pport_pkg::HS_OUT_SETUP; // [R16]
               nxt_cnt = delay;
               nxt_xfer = 1'b1;
               nxt_seen = 1'b0;
            end
         end
         pport_pkg::HS_OUT_SETUP:
         begin
            if (expired)
               nxt_hs = pport_pkg::HS_OUT_RDY; // [R17]
         end
         pport_pkg::HS_OUT_RDY:
         begin
            if (afd_s2_ff && !stb_s2_ff) // [R17] [R20]
            begin
               nxt_hs = pport_pkg::HS_OUT_ACK;
               nxt_cnt = delay;
            end
         end
         pport_pkg::HS_OUT_ACK:
         begin
            if (expired)
            begin
               nxt_cnt = delay; // [R18]
               nxt_hs = (seen_ff || stb_rise) ? pport_pkg::HS_OUT_HOLD : pport_pkg::HS_OUT_STB; // [R21]
            end
         end
         pport_pkg::HS_OUT_STB:
         begin
            if (stb_rise)
            begin
               nxt_hs = pport_pkg::HS_OUT_HOLD; // [R21]
               nxt_cnt = delay;
            end
         end
         pport_pkg::HS_OUT_HOLD:
         begin
            if (expired)
            begin
               nxt_hs = pport_pkg::HS_OUT_REQ;
               nxt_drq = 1'b1; // [R15] [R21]
            end
         end
      endcase
      if (stb_rise && (hs_ff == pport_pkg::HS_OUT_ACK || hs_ff == pport_pkg::HS_OUT_STB))
      begin
         nxt_seen = 1'b1;
         nxt_xfer = 1'b0; // [R19]
      end
      if (reg_wr_done && avs_address == pport_pkg::CTRL_OFS)
      begin
         nxt_ctrl = (ctrl_ff & ~wmask) | (avs_writedata & wmask);
         // a write of 1 to force-ack restarts its interval
         if (avs_writedata[pport_pkg::FORCE_ACK_BIT_BIT] && avs_byteenable[0])
            nxt_fcnt = avs_writedata[pport_pkg::DELAY_MSB:pport_pkg::DELAY_LSB] & {8{avs_byteenable[2]}}
                       | delay & {8{!avs_byteenable[2]}};
      end
      // disabled mode resets the engine but keeps the programmed fields
      if (mode == pport_pkg::MODE_OFF) // [R24]
      begin
         nxt_hs = pport_pkg::HS_IDLE;
         nxt_cnt = 8'h00;
         nxt_bct = 2'h0;
         nxt_drq = 1'b0;
         nxt_xfer = 1'b0;
         nxt_seen = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         hs_ff <= pport_pkg::HS_IDLE;
         ctrl_ff <= pport_pkg::CTRL_RESET;
         cnt_ff <= 8'h00;
         fcnt_ff <= 8'h00;
         bct_ff <= 2'h0;
         drq_ff <= 1'b0;
         xfer_ff <= 1'b0;
         seen_ff <= 1'b0;
      end
      else
      begin
         hs_ff <= nxt_hs;
         ctrl_ff <= nxt_ctrl;
         cnt_ff <= nxt_cnt;
         fcnt_ff <= nxt_fcnt;
         bct_ff <= nxt_bct;
         drq_ff <= nxt_drq;
         xfer_ff <= nxt_xfer;
         seen_ff <= nxt_seen;
      end
   end

   // busy also stands high in disabled mode so the host waits
   assign hw_busy = (mode == pport_pkg::MODE_OFF) || ctrl_ff[pport_pkg::DIR_BIT] // [R13]
                    || (hs_ff == pport_pkg::HS_IN_BUSY);
   assign hw_ack = (mode != pport_pkg::MODE_OFF)
                   && ((hs_ff == pport_pkg::HS_IN_BUSY && !ctrl_ff[pport_pkg::ARB_BIT]) // [R5]
                       || hs_ff == pport_pkg::HS_IN_ACK || hs_ff == pport_pkg::HS_OUT_ACK); // [R9] [R18]
   assign force_ack_bit_on = ctrl_ff[pport_pkg::FORCE_ACK_BIT_BIT];
   assign port_busy = ctrl_ff[pport_pkg::FORCE_BUSY_BIT_BIT] || (!ctrl_ff[pport_pkg::OFF_BIT] && hw_busy); // [R1]
   assign port_ack = force_ack_bit_on || (!ctrl_ff[pport_pkg::OFF_BIT] && hw_ack); // [R1]
   assign irq_req = drq_ff && (mode == pport_pkg::MODE_IRQ); // [R24]
   assign dma_req0 = drq_ff && (mode == pport_pkg::MODE_DMA0);
   assign dma_req1 = drq_ff && (mode == pport_pkg::MODE_DMA1);
endmodule
`default_nettype wire

/* File: core/pport_pkg.sv */
package pport_pkg;
   // register byte offsets on the slave bus
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] DATA_OFS = 8'h08;
   // control register fields
   localparam int DELAY_LSB = 16;
   localparam int DELAY_MSB = 23;
   localparam int DRQ_BIT = 15;
   localparam int XFER_BIT = 14;
   localparam int FWT_BIT = 11;
   localparam int DIR_BIT = 10;
   localparam int MODE_LSB = 8;
   localparam int MODE_MSB = 9;
   localparam int FORCE_BUSY_BIT_BIT = 7;
   localparam int FORCE_ACK_BIT_BIT = 6;
   localparam int OFF_BIT = 5;
   localparam int BRS_BIT = 2;
   localparam int ARB_BIT = 1;
   localparam int AFD_BIT = 0;
   // status register fields
   localparam int STB_BIT = 31;
   localparam int BCT_LSB = 8;
   localparam int BCT_MSB = 9;
   localparam int BSY_BIT = 7;
   localparam int ACK_BIT = 6;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h00FF_0FE6;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_IRQ = 2'h1;
   localparam logic [1:0] MODE_DMA0 = 2'h2;
   localparam logic [1:0] MODE_DMA1 = 2'h3;
   localparam logic [1:0] FWT_LAST = 2'h3;
   // cycles the external buffer strobe stays low
   localparam logic [3:0] BUF_STROBE_CYC = 4'h2;
   typedef enum logic [1:0] {BUS_IDLE, BUS_ARB, BUS_STROBE, BUS_DONE} bus_state_e;
   typedef enum logic [3:0] {
      HS_IDLE, HS_IN_EDGE, HS_IN_BUSY, HS_IN_ACK,
      HS_OUT_REQ, HS_OUT_SETUP, HS_OUT_RDY, HS_OUT_ACK, HS_OUT_STB, HS_OUT_HOLD
   } hs_state_e;
endpackage

/* File: sim/pport_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module pport_chk
(
   input wire logic mclk, // clock
   input wire logic rst_n, // sync reset
   input wire logic [7:0] avs_address, // address
   input wire logic avs_read, // read
   input wire logic avs_write, // write
   input wire logic avs_waitrequest, // stall
   input wire logic host_strobe, // host strobe
   input wire logic port_busy, // busy
   input wire logic irq_req, // irq request
   input wire logic dma_req0, // dma 0 request
   input wire logic dma_req1, // dma 1 request
   input wire logic buf_gnt, // grant
   input wire logic buf_oe_n, // buffer read strobe
   input wire logic buf_we_n // buffer write strobe
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   req_onehot_a: assert property ($onehot0({irq_req, dma_req0, dma_req1}))
      else $error("two service requests at once");
   reg_answer_a: assert property (
      (avs_read || avs_write) && avs_address != pport_pkg::DATA_OFS && avs_waitrequest |=> !avs_waitrequest)
      else $error("register access not answered next cycle");
   oe_width_a: assert property ($fell(buf_oe_n) |=> !buf_oe_n ##1 buf_oe_n)
      else $error("buffer read strobe not two cycles");
   we_width_a: assert property ($fell(buf_we_n) |=> !buf_we_n ##1 buf_we_n)
      else $error("buffer write strobe not two cycles");
   strobe_excl_a: assert property (buf_oe_n || buf_we_n)
      else $error("buffer read and write strobes together");
   grant_first_a: assert property ($fell(buf_oe_n) || $fell(buf_we_n) |-> $past(buf_gnt))
      else $error("buffer strobe without grant");
   data_answer_a: assert property (
      (avs_read || avs_write) && avs_address == pport_pkg::DATA_OFS && !avs_waitrequest
      |-> !$past(buf_oe_n) || !$past(buf_we_n))
      else $error("data access answered before buffer strobe");
   flag_clear_a: assert property (
      (avs_read || avs_write) && avs_address == pport_pkg::DATA_OFS && !avs_waitrequest
      |=> !(irq_req || dma_req0 || dma_req1))
      else $error("request left up after data access");
   busy_drop_a: assert property (
      $fell(port_busy) |-> !$past(host_strobe, 3) && !(irq_req || dma_req0 || dma_req1))
      else $error("busy dropped with strobe high or request pending");
endmodule
`default_nettype wire

/* File: sim/host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_model
#(
   parameter int DATA_W = 32
)
(
   input wire logic mclk, // clock
   output logic host_strobe, // strobe to port
   output logic host_autofeed, // autofeed to port
   input wire logic buf_req, // buffer request
   output logic buf_gnt, // buffer grant
   input wire logic buf_oe_n, // buffer read strobe
   input wire logic buf_we_n, // buffer write strobe
   input wire logic [DATA_W-1:0] buf_wdata, // into buffer
   output logic [DATA_W-1:0] buf_rdata // out of buffer
);
   logic [7:0] host_byte = 8'h00;
   logic [DATA_W-1:0] latch_q = '0;
   logic [DATA_W-1:0] wr_seen = '0;
   initial
   begin
      host_strobe = 1'b0;
      host_autofeed = 1'b0;
      buf_gnt = 1'b0;
   end
   always @(posedge host_strobe)
      latch_q <= {{(DATA_W-8){1'b0}}, host_byte};
   // grant a cycle late, like a loaded arbiter
   always @(posedge mclk)
      buf_gnt <= buf_req;
   always @(posedge mclk)
      if (!buf_we_n)
         wr_seen <= buf_wdata;
   // released buffer shows the inverse so a stale sample cannot match
   assign buf_rdata = buf_oe_n ? ~latch_q : latch_q;
   task automatic drive(input logic s, input logic a, input logic [7:0] b);
      host_byte <= b;
      @(posedge mclk);
      host_strobe <= s;
      host_autofeed <= a;
   endtask
endmodule
`default_nettype wire

/* File: sim/parallel_port_handshake_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module parallel_port_handshake_tb;
   localparam logic [7:0] DLY = 8'h02;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic dma_cycle = 1'b0;
   logic [31:0] avs_readdata, buf_wdata, buf_rdata, q;
   logic avs_waitrequest, host_strobe, host_autofeed, port_ack, port_busy, irq_req, dma_req0, dma_req1;
   logic buf_req, buf_gnt, buf_dma, buf_oe_n, buf_we_n;
   logic [4:0] mon;
   int n_fail = 0;
   int check_count = 0;
   int n;
   assign mon = {dma_req1, dma_req0, irq_req, port_ack, port_busy};
   parallel_port_handshake parallel_port_handshake_i (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dma_cycle(dma_cycle),
      .host_strobe(host_strobe), .host_autofeed(host_autofeed), .port_ack(port_ack), .port_busy(port_busy),
      .irq_req(irq_req), .dma_req0(dma_req0), .dma_req1(dma_req1), .buf_req(buf_req), .buf_gnt(buf_gnt),
      .buf_dma(buf_dma), .buf_oe_n(buf_oe_n), .buf_we_n(buf_we_n), .buf_wdata(buf_wdata), .buf_rdata(buf_rdata));
   host_model host_model_i (.mclk(mclk), .host_strobe(host_strobe), .host_autofeed(host_autofeed),
      .buf_req(buf_req), .buf_gnt(buf_gnt), .buf_oe_n(buf_oe_n), .buf_we_n(buf_we_n), .buf_wdata(buf_wdata),
      .buf_rdata(buf_rdata));
   initial
      forever #5 mclk = ~mclk;
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic dir, input logic full_word_sel, input logic [7:0] lo);
      return {8'h00, DLY, 4'h0, full_word_sel, dir, m, lo};
   endfunction
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      do
      begin
         @(negedge mclk);
         k++;
      end
      while (avs_waitrequest !== 1'b0 && k < 40);
      if (avs_waitrequest !== 1'b0)
      begin
         n_fail++;
         give_verdict;
      end
      q = avs_readdata;
      @(posedge mclk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // counts falling edges until the watched output reaches v, or lim
   task automatic wait_sig(input int s, input logic v, input int lim);
      n = 0;
      @(negedge mclk);
      while (mon[s] !== v && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
   endtask
   task automatic t_inbound(input logic [1:0] m, input logic ack_after_busy, input logic busy_edge_select, input logic [7:0] b);
      int nb;
      bus(1'b1, pport_pkg::CTRL_OFS, ctl(m, 1'b0, 1'b0, {5'h00, busy_edge_select, ack_after_busy, 1'b0}));
      dma_cycle <= m[1];
      host_model_i.drive(1'b1, 1'b0, b);
      // trailing-edge mode keeps busy low; give the leading edge time to set xfer_active
      wait_sig(0, 1'b1, busy_edge_select ? 3 : 10);
      nb = n;
      bus(1'b0, pport_pkg::CTRL_OFS, 32'h0);
      chk(q[pport_pkg::XFER_BIT], 1);
      if (busy_edge_select)
      begin
         @(negedge mclk);
         chk(port_busy, 0);
         host_model_i.drive(1'b0, 1'b0, b);
         wait_sig(0, 1'b1, 10);
         nb = n;
      end
      chk(nb <= 3, 1);
      chk({port_ack, mon[m + 1]}, {!ack_after_busy, 1'b1});
      bus(1'b0, pport_pkg::DATA_OFS, 32'h0);
      chk(q[7:0], b);
      @(negedge mclk);
      chk({buf_dma, mon[m + 1]}, {m[1], 1'b0});
      if (!busy_edge_select)
      begin
         chk(port_busy, 1);
         host_model_i.drive(1'b0, 1'b0, b);
      end
      wait_sig(0, 1'b0, 20);
      chk({port_busy, port_ack}, {1'b0, ack_after_busy});
      wait_sig(1, 1'b0, 20);
      if (ack_after_busy)
         chk(n, DLY);
      bus(1'b0, pport_pkg::CTRL_OFS, 32'h0);
      chk(q[pport_pkg::XFER_BIT], 0);
   endtask
   task automatic t_fullword;
      bus(1'b1, pport_pkg::CTRL_OFS, ctl(2'h1, 1'b0, 1'b1, 8'h00));
      for (int i = 0; i < 4; i++)
      begin
         host_model_i.drive(1'b1, 1'b0, 8'h30);
         wait_sig(0, 1'b1, 10);
         chk(irq_req, i == 3);
         host_model_i.drive(1'b0, 1'b0, 8'h30);
         if (i == 3)
            bus(1'b0, pport_pkg::DATA_OFS, 32'h0);
         wait_sig(0, 1'b0, 20);
         chk(port_busy, 0);
      end
   endtask
   task automatic t_outbound;
      // disable first so the direction bit only moves while mode is off
      bus(1'b1, pport_pkg::CTRL_OFS, ctl(2'h0, 1'b0, 1'b0, 8'h00));
      bus(1'b1, pport_pkg::CTRL_OFS, ctl(2'h0, 1'b1, 1'b0, 8'h00));
      bus(1'b1, pport_pkg::CTRL_OFS, ctl(2'h1, 1'b1, 1'b0, 8'h00));
      repeat (2) @(negedge mclk);
      chk({port_busy, irq_req}, 2'h3);
      bus(1'b1, pport_pkg::DATA_OFS, 32'hC3A5_5A3C);
      chk(host_model_i.wr_seen, 32'hC3A5_5A3C);
      wait_sig(1, 1'b1, 12);
      chk(n, 12);
      bus(1'b0, pport_pkg::CTRL_OFS, 32'h0);
      chk({q[pport_pkg::XFER_BIT], q[pport_pkg::AFD_BIT]}, 2'h2);
      host_model_i.drive(1'b0, 1'b1, 8'h00);
      wait_sig(1, 1'b1, 6);
      chk(n <= 3, 1);
      wait_sig(1, 1'b0, 20);
      chk({n[7:0], irq_req}, {DLY, 1'b0});
      host_model_i.drive(1'b1, 1'b1, 8'h00);
      wait_sig(2, 1'b1, 20);
      chk(n >= DLY + 3 && n < 20, 1);
      bus(1'b0, pport_pkg::CTRL_OFS, 32'h0);
      chk({q[pport_pkg::XFER_BIT], q[pport_pkg::AFD_BIT]}, 2'h1);
      host_model_i.drive(1'b0, 1'b0, 8'h00);
      wait_sig(1, 1'b1, 30);
      chk(n, 30);
      bus(1'b1, pport_pkg::CTRL_OFS, ctl(2'h0, 1'b1, 1'b0, 8'h00));
      bus(1'b1, pport_pkg::CTRL_OFS, 32'h0);
   endtask
   task automatic t_force;
      bus(1'b1, pport_pkg::CTRL_OFS, ctl(2'h1, 1'b0, 1'b0, 8'hE0));
      @(negedge mclk);
      chk({port_busy, port_ack}, 2'h3);
      bus(1'b1, pport_pkg::CTRL_OFS, ctl(2'h1, 1'b0, 1'b0, 8'h20));
      wait_sig(1, 1'b0, 10);
      chk({port_busy, port_ack}, 2'h0);
      bus(1'b1, pport_pkg::CTRL_OFS, 32'h0);
      @(negedge mclk);
      chk({port_busy, port_ack}, 2'h2);
   endtask
   initial
   begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      chk({port_busy, port_ack, mon[4:2]}, 5'h10);
      bus(1'b0, pport_pkg::CTRL_OFS, 32'h0);
      chk(q, pport_pkg::CTRL_RESET);
      bus(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      t_inbound(2'h1, 1'b0, 1'b0, 8'hA5);
      t_inbound(2'h2, 1'b1, 1'b0, 8'h5A);
      t_inbound(2'h3, 1'b0, 1'b1, 8'h96);
      t_inbound(2'h1, 1'b1, 1'b1, 8'h69);
      t_fullword;
      t_outbound;
      t_force;
      give_verdict;
   end
endmodule
bind parallel_port_handshake pport_chk pport_chk_i (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .host_strobe(host_strobe),
   .port_busy(port_busy), .irq_req(irq_req), .dma_req0(dma_req0), .dma_req1(dma_req1), .buf_gnt(buf_gnt),
   .buf_oe_n(buf_oe_n), .buf_we_n(buf_we_n));
`default_nettype wire
